//--- rtl/charge_sequencer.sv
// charge sequencing state machine for a 1 to 4 cell li+ step-down charger
// assumes synchronous digitised comparators, open-drain indicator pads
// and an apb master on the same clock
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "charge_params.svh"

// Overview of operation
// RULE_01: power-on, or done exit conditions, enter reset
// RULE_02: reset clears timers, no current, indicators released
// RULE_03: leave reset once bias ready reported
// RULE_04: prequal: tenth current, 7.5min timer, cc low
// RULE_05: prequal to fast when above uv, temperature ok
// RULE_06: fast: constant current, 90min timer b, cc low
// RULE_07: fast to full on regulation voltage reached
// RULE_08: full: constant voltage, 90min timer, cv low
// RULE_09: full to topoff on timeout or termination current
// RULE_10: topoff: cv, indicators high, 45min, then done
// RULE_11: done: no current, recharge threshold restarts cycle
// RULE_12: fault from reset hot, prequal/fast timeouts
// RULE_13: fault: no current, fault indicator low
// RULE_14: temperature out: pause, freeze timer, keep indicators
// RULE_15: prequal temperature out pauses charge and timer
// RULE_16: power-down low disables, high enters reset
// RULE_17: four-level strap decodes one to four cells
// RULE_18: fault cleared only by power cycle or power-down
// RULE_19: shutdown: switch off, indicators hi-z, exit via reset
// RULE_20: suspended timer keeps count, resumes from it
// RULE_21: inputs synchronised, one transition per clock
module charge_sequencer
  import charge_pkg::*;
#(
  parameter int                      TIMER_W       = `TIMER_WIDTH,
  parameter logic [31:0]             TICK_CYCLES   = 32'(`TICK_CYCLES),
  parameter logic [TIMER_W-1:0]      PREQUAL_TICKS = TIMER_W'(`PREQUAL_TICKS),
  parameter logic [TIMER_W-1:0]      FULL_TICKS    = TIMER_W'(`FULL_TICKS),
  parameter logic [TIMER_W-1:0]      TOPOFF_TICKS  = TIMER_W'(`TOPOFF_TICKS),
  parameter logic [TIMER_W-1:0]      FAST_TICKS    = TIMER_W'(`FAST_TICKS)
)(
  input  wire logic                  MCLK,
  input  wire logic                  RSTN,
  input  wire charge_pkg::sense_t    SENSE,
  input  wire logic                  POWER_DOWN_N,
  input  wire charge_pkg::ind_t      IND_I,
  output var  charge_pkg::ind_t      IND_O,
  output var  charge_pkg::ind_t      IND_OE,
  output var  charge_pkg::chg_mode_t CHARGE_MODE,
  output var  logic                  POWER_SWITCH_EN,
  output var  logic [1:0]            CELL_COUNT,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output var  logic [31:0]           PRDATA,
  output var  logic                  PREADY,
  output var  logic                  PSLVERR
);
  import charge_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  sense_t           sense_s1_reg;
  sense_t           sense_reg;
  logic             pd_n_s1_reg;
  logic             pd_n_reg;
  ind_t             pin_s1_reg;
  ind_t             pin_reg;

  // two flops on every pad input; only the second stage is used
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sense_s1_reg <= '0;
      sense_reg    <= '0;
      pd_n_s1_reg  <= 1'b0;
      pd_n_reg     <= 1'b0;
      pin_s1_reg   <= '0;
      pin_reg      <= '0;
    end
    else
    begin
      sense_s1_reg <= SENSE; // [RULE_21]
      sense_reg    <= sense_s1_reg;
      pd_n_s1_reg  <= POWER_DOWN_N;
      pd_n_reg     <= pd_n_s1_reg;
      pin_s1_reg   <= IND_I;
      pin_reg      <= pin_s1_reg;
    end
  end

  // ****************************************
  // timer tick prescaler
  // ****************************************
  logic [31:0]      tick_div_reg;
  logic [31:0]      tick_div_next;
  logic [31:0]      tick_cnt_reg;
  logic [31:0]      tick_cnt_next;
  wire logic        tick;

  // one tick every tick_div clocks; zero behaves as one
  assign tick          = (tick_div_reg <= 32'h0000_0001) ||
                         (tick_cnt_reg >= tick_div_reg - 32'h0000_0001);
  assign tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_next;
  end

  // ****************************************
  // state machine
  // ****************************************
  chg_state_t       state_reg;
  chg_state_t       state_next;
  logic [TIMER_W-1:0] timer_a_reg;
  logic [TIMER_W-1:0] timer_a_next;
  logic [TIMER_W-1:0] timer_b_reg;
  logic [TIMER_W-1:0] timer_b_next;
  logic [TIMER_W-1:0] limit_a;
  wire logic        in_prequal;
  wire logic        in_fast;
  wire logic        in_full;
  wire logic        in_topoff;
  wire logic        charging;
  wire logic        suspended;
  wire logic        a_expired;
  wire logic        b_expired;
  wire logic        done_exit;

  assign in_prequal = (state_reg == ST_PREQUAL);
  assign in_fast    = (state_reg == ST_FAST);
  assign in_full    = (state_reg == ST_FULL);
  assign in_topoff  = (state_reg == ST_TOPOFF);
  assign charging   = in_prequal | in_fast | in_full | in_topoff;
  assign suspended  = charging & ~sense_reg.temp_ok; // [RULE_14] [RULE_15]
  assign a_expired  = (timer_a_reg >= limit_a);
  assign b_expired  = (timer_b_reg >= FAST_TICKS);
  assign done_exit  = sense_reg.recharge_low | sense_reg.dropout |
                      sense_reg.over_volt; // [RULE_01] [RULE_11]

  // timer a limit follows the phase that owns it
  always_comb
  begin
    limit_a = '1;
    if (in_prequal)
      limit_a = PREQUAL_TICKS; // [RULE_04]
    else if (in_full)
      limit_a = FULL_TICKS; // [RULE_08]
    else if (in_topoff)
      limit_a = TOPOFF_TICKS; // [RULE_10]
  end

  // next state; power-down overrides everything, one step per clock
  always_comb
  begin
    state_next = state_reg;
    if (!pd_n_reg)
      state_next = ST_SHUTDOWN; // [RULE_16] [RULE_19]
    else
    begin
      unique case (state_reg)
        ST_SHUTDOWN: state_next = ST_RESET; // [RULE_16]
        ST_RESET:
          if (sense_reg.temp_hot)
            state_next = ST_FAULT; // [RULE_12]
          else if (sense_reg.bias_ready)
            state_next = ST_PREQUAL; // [RULE_03]
        ST_PREQUAL:
          if (!suspended && sense_reg.above_uv)
            state_next = ST_FAST; // [RULE_05]
          else if (!suspended && a_expired)
            state_next = ST_FAULT; // [RULE_12]
        ST_FAST:
          if (!suspended && sense_reg.reg_reached)
            state_next = ST_FULL; // [RULE_07]
          else if (!suspended && b_expired)
            state_next = ST_FAULT; // [RULE_12]
        ST_FULL:
          if (!suspended && (a_expired || sense_reg.term_current))
            state_next = ST_TOPOFF; // [RULE_09]
        ST_TOPOFF:
          if (!suspended && a_expired)
            state_next = ST_DONE; // [RULE_10]
        ST_DONE:
          if (done_exit)
            state_next = ST_RESET; // [RULE_01] [RULE_11]
        ST_FAULT: state_next = ST_FAULT; // [RULE_18]
        default: state_next = ST_RESET;
      endcase
    end
  end

  // timers clear on every phase change and in reset; hold while paused
  wire logic        phase_change;
  wire logic        run_a;
  wire logic        run_b;
  assign phase_change = (state_next != state_reg) ||
                        (state_reg == ST_RESET) || (state_reg == ST_SHUTDOWN);
  assign run_a        = (in_prequal | in_full | in_topoff) & ~suspended & ~a_expired;
  assign run_b        = in_fast & ~suspended & ~b_expired;
  assign timer_a_next = phase_change ? '0 :
                        (run_a && tick) ? timer_a_reg + TIMER_W'(1) : timer_a_reg; // [RULE_20]
  assign timer_b_next = phase_change ? '0 :
                        (run_b && tick) ? timer_b_reg + TIMER_W'(1) : timer_b_reg; // [RULE_20]

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_reg   <= ST_RESET; // [RULE_01]
      timer_a_reg <= '0;
      timer_b_reg <= '0;
    end
    else
    begin
      state_reg   <= state_next;
      timer_a_reg <= timer_a_next; // [RULE_02]
      timer_b_reg <= timer_b_next;
    end
  end

  // ****************************************
  // charge command, indicators, cell count
  // ****************************************
  chg_mode_t        mode_next;
  ind_t             oe_next;
  logic [1:0]       cell_next;

  // zero current outside the four charging phases or while paused
  always_comb
  begin
    mode_next = MODE_OFF; // [RULE_02] [RULE_11] [RULE_13]
    if (!suspended)
    begin
      if (in_prequal)
        mode_next = MODE_TENTH; // [RULE_04]
      else if (in_fast)
        mode_next = MODE_CC; // [RULE_06]
      else if (in_full || in_topoff)
        mode_next = MODE_CV; // [RULE_08] [RULE_10]
    end
  end

  // an enable pulls the pad low; indicators depend on state only
  assign oe_next.cc    = in_prequal | in_fast; // [RULE_04] [RULE_06]
  assign oe_next.cv    = in_full; // [RULE_08]
  assign oe_next.fault = (state_reg == ST_FAULT); // [RULE_13]

  // thermometer strap: ground, float, reference, supply
  assign cell_next = sense_reg.cell_gt_ref ? 2'h3 :
                     sense_reg.cell_gt_mid ? 2'h2 :
                     sense_reg.cell_gt_gnd ? 2'h1 : 2'h0; // [RULE_17]

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CHARGE_MODE     <= MODE_OFF;
      POWER_SWITCH_EN <= 1'b0;
      IND_OE          <= '0;
      IND_O           <= '0;
      CELL_COUNT      <= 2'h0;
    end
    else
    begin
      CHARGE_MODE     <= mode_next;
      POWER_SWITCH_EN <= (mode_next != MODE_OFF); // [RULE_19]
      IND_OE          <= oe_next; // [RULE_02] [RULE_19]
      IND_O           <= '0;
      CELL_COUNT      <= cell_next;
    end
  end

  // ****************************************
  // apb register slave
  // ****************************************
  wire logic        hit_status;
  wire logic        hit_tick;
  wire logic        access;
  wire logic        wr_tick;
  logic [31:0]      status_word;
  logic [31:0]      rd_data;

  assign hit_status    = (PADDR == `STATUS_ADDR);
  assign hit_tick      = (PADDR == `TICK_DIV_ADDR);
  assign access        = PSEL & PENABLE & ~PREADY;
  assign wr_tick       = PSEL & PENABLE & PREADY & PWRITE & hit_tick;
  assign tick_div_next = wr_tick ? PWDATA : tick_div_reg;

  // status word shows state, command, strap, pause and pad levels
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`ST_STATE_LSB +: 8] = state_reg;
    status_word[`ST_MODE_LSB +: 2]  = CHARGE_MODE;
    status_word[`ST_CELL_LSB +: 2]  = CELL_COUNT;
    status_word[`ST_SUSP_BIT]       = suspended;
    status_word[`ST_PIN_LSB +: 3]   = pin_reg;
  end

  assign rd_data = hit_status ? status_word :
                   hit_tick   ? tick_div_reg : 32'h0000_0000;

  // one wait state; writes land at the completing edge
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY       <= 1'b0;
      PRDATA       <= 32'h0000_0000;
      PSLVERR      <= 1'b0;
      tick_div_reg <= TICK_CYCLES;
    end
    else
    begin
      PREADY       <= access;
      PRDATA       <= access ? rd_data : 32'h0000_0000;
      PSLVERR      <= access & ~(hit_tick | (hit_status & ~PWRITE));
      tick_div_reg <= tick_div_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  a_state_one_hot: assert property ($onehot(state_reg)) // [RULE_21]
    else $error("state is not one-hot");
  a_reset_quiet: assert property (state_reg == ST_RESET |-> timer_a_reg == '0 && timer_b_reg == '0 ##1 CHARGE_MODE == MODE_OFF && IND_OE == '0) // [RULE_02]
    else $error("reset state not quiet");
  a_prequal_drive: assert property (in_prequal && sense_reg.temp_ok |=> CHARGE_MODE == MODE_TENTH && IND_OE == 3'b100) // [RULE_04]
    else $error("prequal drive wrong");
  a_fast_drive: assert property (in_fast && sense_reg.temp_ok |=> CHARGE_MODE == MODE_CC && IND_OE.cc && !IND_OE.cv) // [RULE_06]
    else $error("fast charge drive wrong");
  a_full_drive: assert property (in_full && sense_reg.temp_ok |=> CHARGE_MODE == MODE_CV && IND_OE == 3'b010) // [RULE_08]
    else $error("full charge drive wrong");
  a_fault_sticky: assert property (state_reg == ST_FAULT && pd_n_reg |=> state_reg == ST_FAULT ##1 IND_OE == 3'b001) // [RULE_18]
    else $error("fault left without power-down");
  a_shutdown_hiz: assert property (!pd_n_reg |=> state_reg == ST_SHUTDOWN ##1 IND_OE == '0 && !POWER_SWITCH_EN) // [RULE_19]
    else $error("shutdown outputs wrong");
  a_pause_freeze: assert property (suspended && state_next == state_reg |=> $stable(timer_a_reg) && $stable(timer_b_reg)) // [RULE_20]
    else $error("timer moved while paused");
  a_pause_keeps_ind: assert property (suspended && pd_n_reg && $stable(state_reg) |=> CHARGE_MODE == MODE_OFF && IND_OE == $past(IND_OE)) // [RULE_14]
    else $error("pause changed indicators");
  a_fast_timeout: assert property (in_fast && b_expired && sense_reg.temp_ok && !sense_reg.reg_reached && pd_n_reg |=> state_reg == ST_FAULT) // [RULE_12]
    else $error("fast timeout missed");
  a_done_restart: assert property (state_reg == ST_DONE && pd_n_reg && sense_reg.recharge_low |=> state_reg == ST_RESET) // [RULE_11]
    else $error("recharge restart missed");

  c_full_cycle: cover property (state_reg == ST_TOPOFF ##1 state_reg == ST_DONE);
  c_fault_entry: cover property (in_prequal ##1 state_reg == ST_FAULT);
  c_pause: cover property (in_full && suspended ##1 in_full && !suspended);
  c_apb_write: cover property (wr_tick);

endmodule
`default_nettype wire

//--- rtl/charge_params.svh
// constants for the battery charge sequencer: offsets, fields, resets, times
// assumes a 100 MHz core clock and a 1 ms timer tick
`ifndef CHARGE_PARAMS_SVH
`define CHARGE_PARAMS_SVH

// clock and tick timing
`define CLK_PERIOD_NS      10
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_PERIOD_MS     1
`define MS_PER_DMIN        6000

// phase limits in tenths of a minute
`define PREQUAL_TIME_DMIN  75
`define FULL_TIME_DMIN     900
`define TOPOFF_TIME_DMIN   450
`define FAST_TIME_DMIN     900

// phase limits in timer ticks
`define PREQUAL_TICKS      (`PREQUAL_TIME_DMIN * `MS_PER_DMIN / `TICK_PERIOD_MS)
`define FULL_TICKS         (`FULL_TIME_DMIN * `MS_PER_DMIN / `TICK_PERIOD_MS)
`define TOPOFF_TICKS       (`TOPOFF_TIME_DMIN * `MS_PER_DMIN / `TICK_PERIOD_MS)
`define FAST_TICKS         (`FAST_TIME_DMIN * `MS_PER_DMIN / `TICK_PERIOD_MS)
`define TIMER_WIDTH        23

// register map
`define STATUS_ADDR        12'h000
`define TICK_DIV_ADDR      12'h004

// status word fields
`define ST_STATE_LSB       0
`define ST_MODE_LSB        8
`define ST_CELL_LSB        10
`define ST_SUSP_BIT        12
`define ST_PIN_LSB         13

`endif

//--- rtl/charge_pkg.sv
// types shared by the battery charge sequencer
// assumes charge_params.svh holds all numeric constants
`default_nettype none
package charge_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_RESET    = 8'h01,
    ST_PREQUAL  = 8'h02,
    ST_FAST     = 8'h04,
    ST_FULL     = 8'h08,
    ST_TOPOFF   = 8'h10,
    ST_DONE     = 8'h20,
    ST_FAULT    = 8'h40,
    ST_SHUTDOWN = 8'h80
  } chg_state_t;

  // charge current command to the regulation loops
  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_TENTH = 2'h1,
    MODE_CC    = 2'h2,
    MODE_CV    = 2'h3
  } chg_mode_t;

  // digitised comparator results from the analog front end
  typedef struct packed {
    logic bias_ready;
    logic above_uv;
    logic over_volt;
    logic reg_reached;
    logic term_current;
    logic temp_ok;
    logic temp_hot;
    logic dropout;
    logic recharge_low;
    logic cell_gt_gnd;
    logic cell_gt_mid;
    logic cell_gt_ref;
  } sense_t;

  // one bit per status indicator
  typedef struct packed {
    logic cc;
    logic cv;
    logic fault;
  } ind_t;

endpackage
`default_nettype wire

//--- tb/indicator_pads.sv
// board model around the charge sequencer: pulled-up indicator pads and cell strap
// assumes an enabled pad is pulled low and a released pad is pulled up
`timescale 1ns/1ps
`default_nettype none
module indicator_pads
(
  input  wire charge_pkg::ind_t pad_oe,
  input  wire logic [1:0]       strap,
  output var  charge_pkg::ind_t pad_level,
  output var  logic [2:0]       strap_bits
);
  import charge_pkg::*;

  // *************************************
  // pads and strap
  // *************************************
  // a released pad reads high through its pull-up, never the last driven level
  assign pad_level  = ind_t'(~pad_oe);
  // strap level seen as a thermometer {above gnd, above mid, above ref}
  assign strap_bits = {strap >= 2'h1, strap >= 2'h2, strap == 2'h3};
endmodule
`default_nettype wire

//--- tb/liion_charge_state_machine_bench.sv
// self-checking bench for the charge sequencer: apb tasks and sense sequences
// assumes shortened timer limits and the pad model beside the design
`timescale 1ns/1ps
`default_nettype none
`include "charge_params.svh"
module liion_charge_state_machine_bench;
  import charge_pkg::*;

  // *************************************
  // signals and instances
  // *************************************
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        power_down_n = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0]  strap = 2'h0;
  sense_t      sense_drv;
  sense_t      sense_in;
  ind_t        ind_i;
  ind_t        ind_o;
  ind_t        ind_oe;
  chg_mode_t   mode;
  logic        sw_en;
  logic [1:0]  cell_count;
  logic [2:0]  strap_bits;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          num_errors = 0;
  int          n_checks = 0;

  // cell strap bits come from the board model
  assign sense_in = {sense_drv[11:3], strap_bits};

  charge_sequencer #(
    .TICK_CYCLES(32'h0000_0001), .PREQUAL_TICKS(23'h8), .FULL_TICKS(23'ha),
    .TOPOFF_TICKS(23'h6), .FAST_TICKS(23'ha)
  ) charge_sequencer_i (
    .MCLK(mclk), .RSTN(rstn), .SENSE(sense_in), .POWER_DOWN_N(power_down_n),
    .IND_I(ind_i), .IND_O(ind_o), .IND_OE(ind_oe), .CHARGE_MODE(mode),
    .POWER_SWITCH_EN(sw_en), .CELL_COUNT(cell_count), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );

  indicator_pads indicator_pads_i (
    .pad_oe(ind_oe), .strap(strap), .pad_level(ind_i), .strap_bits(strap_bits)
  );

  // free-running 100 MHz clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // *************************************
  // tasks
  // *************************************
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'(pready), 32'h0000_0001);
    if (pready !== 1'b1)
      conclude();
  endtask

  task automatic expect_reg(input string what, input logic [11:0] a,
                            input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(what, rd & mask, exp);
    check("pslverr", 32'(err), 32'h0000_0000);
  endtask

  task automatic expect_err(input logic wr, input logic [11:0] a);
    logic [31:0] rd;
    logic        err;
    apb(wr, a, 32'h0000_0055, rd, err);
    check("pslverr", 32'(err), 32'h0000_0001);
  endtask

  // waits a bounded time for a mode and indicator pattern
  task automatic wait_for(input chg_mode_t m, input logic [2:0] oe, input int lim);
    int n;
    n = 0;
    while ((mode !== m || ind_oe !== oe) && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check("mode", 32'(mode), 32'(m));
    check("indicators", 32'(ind_oe), 32'(oe));
    if (mode !== m || ind_oe !== oe)
      conclude();
  endtask

  // *************************************
  // main sequence
  // *************************************
  initial
  begin
    logic [31:0] rd;
    logic        err;
    sense_drv = 12'h000;
    sense_drv.temp_ok = 1'b1;
    repeat (3) @(posedge mclk);
    check("mode in reset", 32'(mode), 32'h0000_0000);
    rstn <= 1'b1;
    expect_reg("tick div", `TICK_DIV_ADDR, 32'h0000_0001, 32'hffff_ffff);
    apb(1'b1, `TICK_DIV_ADDR, 32'h0000_0014, rd, err);
    expect_reg("tick div", `TICK_DIV_ADDR, 32'h0000_0014, 32'hffff_ffff);
    expect_err(1'b0, 12'h008);
    expect_err(1'b1, `STATUS_ADDR);
    repeat (20) @(posedge mclk);
    expect_reg("state", `STATUS_ADDR, 32'h0000_0001, 32'h0000_00ff);
    check("released", 32'(ind_oe), 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      strap <= 2'(i);
      repeat (6) @(posedge mclk);
      check("cells", 32'(cell_count), 32'(i));
    end
    sense_drv.bias_ready <= 1'b1;
    wait_for(MODE_TENTH, 3'b100, 20);
    sense_drv.temp_ok <= 1'b0;
    wait_for(MODE_OFF, 3'b100, 10);
    repeat (250) @(posedge mclk);
    sense_drv.temp_ok <= 1'b1;
    wait_for(MODE_TENTH, 3'b100, 10);
    expect_reg("state", `STATUS_ADDR, 32'h0000_0002, 32'h0000_00ff);
    sense_drv.above_uv <= 1'b1;
    wait_for(MODE_CC, 3'b100, 10);
    check("switch", 32'(sw_en), 32'h0000_0001);
    sense_drv.reg_reached <= 1'b1;
    wait_for(MODE_CV, 3'b010, 10);
    sense_drv.reg_reached <= 1'b0;
    sense_drv.term_current <= 1'b1;
    wait_for(MODE_CV, 3'b000, 10);
    sense_drv.term_current <= 1'b0;
    sense_drv.temp_ok <= 1'b0;
    wait_for(MODE_OFF, 3'b000, 10);
    repeat (300) @(posedge mclk);
    sense_drv.temp_ok <= 1'b1;
    wait_for(MODE_CV, 3'b000, 10);
    expect_reg("state", `STATUS_ADDR, 32'h0000_0010, 32'h0000_00ff);
    wait_for(MODE_OFF, 3'b000, 200);
    expect_reg("state", `STATUS_ADDR, 32'h0000_0020, 32'h0000_00ff);
    sense_drv.recharge_low <= 1'b1;
    wait_for(MODE_CC, 3'b100, 20);
    sense_drv.recharge_low <= 1'b0;
    wait_for(MODE_OFF, 3'b001, 300);
    sense_drv.reg_reached <= 1'b1;
    repeat (50) @(posedge mclk);
    expect_reg("state", `STATUS_ADDR, 32'h0000_0040, 32'h0000_00ff);
    check("pad data", 32'(ind_o), 32'h0000_0000);
    sense_drv.reg_reached <= 1'b0;
    power_down_n <= 1'b0;
    wait_for(MODE_OFF, 3'b000, 20);
    check("switch", 32'(sw_en), 32'h0000_0000);
    expect_reg("pads", `STATUS_ADDR, 32'h0000_e080, 32'h0000_e0ff);
    sense_drv.above_uv <= 1'b0;
    power_down_n <= 1'b1;
    wait_for(MODE_TENTH, 3'b100, 20);
    wait_for(MODE_OFF, 3'b001, 300);
    power_down_n <= 1'b0;
    sense_drv.temp_hot <= 1'b1;
    wait_for(MODE_OFF, 3'b000, 20);
    power_down_n <= 1'b1;
    wait_for(MODE_OFF, 3'b001, 20);
    // second power-on in mid-run, then a cycle ended by timers and dropout
    sense_drv.temp_hot <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    check("mode in reset", 32'(mode), 32'h0000_0000);
    check("released", 32'(ind_oe), 32'h0000_0000);
    rstn <= 1'b1;
    sense_drv.above_uv <= 1'b1;
    sense_drv.reg_reached <= 1'b1;
    wait_for(MODE_CV, 3'b010, 30);
    wait_for(MODE_CV, 3'b000, 30);
    wait_for(MODE_OFF, 3'b000, 30);
    sense_drv.dropout <= 1'b1;
    wait_for(MODE_CV, 3'b010, 30);
    conclude();
  end
endmodule
`default_nettype wire
